//--- cpu_instruction_cycle_timing.sv
// instruction length and cycle-count decode plus execution sequencer
// assumes opcode, branch result and store enable come from the same clock
//
// Notes on behaviour
// RQ1: every instruction is timed in plain clocks, no machine cycles.
// RQ2: an instruction normally takes as many clocks as it has bytes.
// RQ3: a conditional branch not taken ends one clock before taken.
// RQ4: register-source arithmetic, logic, inc and dec: one byte, one clock.
// RQ5: direct-operand accumulator ops and direct inc/dec: two bytes, two.
// RQ6: indirect-operand arithmetic, logic, inc, dec: one byte, two clocks.
// RQ7: immediate accumulator arithmetic and logic: two bytes, two clocks.
// RQ8: logic of immediate into direct byte: three bytes, three clocks.
// RQ9: logic of accumulator into direct byte: two bytes, two clocks.
// RQ10: one-byte accumulator ops such as clear, rotate, swap: one clock.
// RQ11: direct-to-direct and immediate-to-direct moves: three bytes, three.
// RQ12: accumulator to indirect memory: one byte, two clocks.
// RQ13: immediate or direct to indirect, indirect to direct: two, two.
// RQ14: load working register from direct or immediate: two, two.
// RQ15: load data pointer with 16-bit constant: three bytes, three clocks.
// RQ16: both code-memory reads: one byte, three clocks.
// RQ17: all six external-data moves: one byte, three clocks.
// RQ18: external-data write is the path to write program flash.
// RQ19: no external bus; external-data moves reach only on-chip storage.
// RQ20: push and pop of a direct byte: two bytes, two clocks.
// RQ21: exchange with register one byte one clock; with direct two, two.
// RQ22: no instruction takes more than eight clocks.
// RQ23: the spare opcode behaves exactly like no-operation.
// RQ24: multiply takes four clocks, divide eight, both one byte.
// RQ25: length comes from the opcode byte alone, known at acceptance.
module cpu_instruction_cycle_timing (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       op_valid,
  input  wire logic [7:0] op_byte,
  output logic            op_ready,
  input  wire logic       branch_taken,
  input  wire logic       store_write_en,
  output logic            busy,
  output logic            inst_done,
  output logic [1:0]      inst_len,
  output logic [3:0]      inst_cycles,
  output logic            inst_cond,
  output logic [7:0]      cur_opcode,
  output logic            code_rd_stb,
  output logic            xram_rd_stb,
  output logic            xram_wr_stb,
  output logic            flash_wr_stb
);

  localparam int LW = cycle_timing_pkg::LEN_W;
  localparam int CW = cycle_timing_pkg::CYC_W;

  cycle_timing_pkg::seq_state_type state_reg;
  cycle_timing_pkg::seq_state_type state_next;

  logic [cycle_timing_pkg::ENT_W-1:0] entry;
  logic [LW-1:0] dec_len;
  logic [CW-1:0] dec_cyc;
  logic          dec_cond;
  logic [LW-1:0] len_reg;
  logic [CW-1:0] cyc_reg;
  logic          cond_reg;
  logic [7:0]    opcode_reg;
  logic          store_we_reg;
  logic [CW-1:0] count;
  logic          accept;
  logic          last_cycle;
  logic          skip_cycle;
  logic          is_movx_wr;
  logic          is_movx_rd;
  logic          is_movc;
  logic [CW-1:0] elapsed_reg;

  // opcode map decode by column, then row
  always_comb begin
    entry = cycle_timing_pkg::E11;
    case (op_byte[3:0])
      4'h0: begin
        case (op_byte[7:4])
          4'h0: entry = cycle_timing_pkg::E11;
          4'h1, 4'h2, 4'h3: entry = cycle_timing_pkg::C34; // RQ3
          4'h4, 4'h5, 4'h6, 4'h7: entry = cycle_timing_pkg::C23; // RQ3
          4'h8: entry = cycle_timing_pkg::E23;
          4'h9: entry = cycle_timing_pkg::E33; // RQ15
          4'hc, 4'hd: entry = cycle_timing_pkg::E22; // RQ20
          4'he, 4'hf: entry = cycle_timing_pkg::E13; // RQ17
          default: entry = cycle_timing_pkg::E22;
        endcase
      end
      4'h1: begin
        entry = cycle_timing_pkg::E23;
      end
      4'h2: begin
        case (op_byte[7:4])
          4'h0, 4'h1: entry = cycle_timing_pkg::E34;
          4'h2, 4'h3: entry = cycle_timing_pkg::E15;
          4'he, 4'hf: entry = cycle_timing_pkg::E13; // RQ17
          default: entry = cycle_timing_pkg::E22; // RQ9
        endcase
      end
      4'h3: begin
        case (op_byte[7:4])
          4'h4, 4'h5, 4'h6: entry = cycle_timing_pkg::E33; // RQ8
          4'h8, 4'h9: entry = cycle_timing_pkg::E13; // RQ16
          4'h7, 4'he, 4'hf: entry = cycle_timing_pkg::E13; // RQ17
          default: entry = cycle_timing_pkg::E11; // RQ10
        endcase
      end
      4'h4: begin
        case (op_byte[7:4])
          4'h8: entry = cycle_timing_pkg::E18; // RQ24 RQ22
          4'ha: entry = cycle_timing_pkg::E14; // RQ24
          4'hb: entry = cycle_timing_pkg::C34;
          4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: begin
            entry = cycle_timing_pkg::E11; // RQ4 RQ10
          end
          default: entry = cycle_timing_pkg::E22; // RQ7 RQ14
        endcase
      end
      4'h5: begin
        case (op_byte[7:4])
          4'h7, 4'h8: entry = cycle_timing_pkg::E33; // RQ11
          4'ha: entry = cycle_timing_pkg::E11; // RQ23
          4'hb, 4'hd: entry = cycle_timing_pkg::C34;
          default: entry = cycle_timing_pkg::E22; // RQ5 RQ21
        endcase
      end
      4'h6, 4'h7: begin
        case (op_byte[7:4])
          4'h7, 4'h8, 4'ha: entry = cycle_timing_pkg::E22; // RQ13
          4'hb: entry = cycle_timing_pkg::C35;
          default: entry = cycle_timing_pkg::E12; // RQ6 RQ12
        endcase
      end
      default: begin
        case (op_byte[7:4])
          4'h7, 4'h8, 4'ha: entry = cycle_timing_pkg::E22; // RQ14
          4'hb: entry = cycle_timing_pkg::C34;
          4'hd: entry = cycle_timing_pkg::C23;
          default: entry = cycle_timing_pkg::E11; // RQ4 RQ21
        endcase
      end
    endcase
  end

  // length depends on the opcode byte only, nothing fetched later
  assign dec_len  = entry[cycle_timing_pkg::ENT_LEN_LSB +: LW]; // RQ25
  assign dec_cyc  = entry[cycle_timing_pkg::ENT_CYC_LSB +: CW];
  assign dec_cond = entry[cycle_timing_pkg::ENT_COND_BIT];

  exec_cycle_counter #(
    .W (CW)
  ) u_counter (
    .clock      (clock),
    .rst        (rst),
    .load       (accept),
    .load_value (dec_cyc),
    .count      (count)
  );

  // branch result is looked at only in the second-to-last taken clock
  assign skip_cycle = cond_reg && (count == CW'(2)) && !branch_taken; // RQ3
  assign last_cycle = (state_reg == cycle_timing_pkg::ST_EXEC)
                      && ((count == CW'(1)) || skip_cycle); // RQ2
  // pipelined: next opcode may be taken in the last clock
  assign op_ready   = (state_reg == cycle_timing_pkg::ST_IDLE)
                      || last_cycle;
  assign accept     = op_valid && op_ready;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cycle_timing_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = cycle_timing_pkg::ST_EXEC;
        end
      end
      cycle_timing_pkg::ST_EXEC: begin
        if (last_cycle && !accept) begin
          state_next = cycle_timing_pkg::ST_IDLE;
        end
      end
      default: state_next = cycle_timing_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= cycle_timing_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction held for its whole execution
  always_ff @(posedge clock) begin
    if (rst) begin
      opcode_reg   <= cycle_timing_pkg::OP_NOP;
      len_reg      <= '0;
      cyc_reg      <= '0;
      cond_reg     <= 1'b0;
      store_we_reg <= 1'b0;
    end else if (accept) begin
      opcode_reg   <= op_byte;
      len_reg      <= dec_len;
      cyc_reg      <= dec_cyc;
      cond_reg     <= dec_cond;
      store_we_reg <= store_write_en;
    end
  end

  // clocks spent so far, only for the checks below
  always_ff @(posedge clock) begin
    if (rst) begin
      elapsed_reg <= '0;
    end else if (accept) begin
      elapsed_reg <= CW'(1);
    end else if (state_reg == cycle_timing_pkg::ST_EXEC) begin
      elapsed_reg <= elapsed_reg + CW'(1);
    end
  end

  assign is_movx_wr = (opcode_reg == cycle_timing_pkg::OP_XWR_DPTR)
                      || (opcode_reg == cycle_timing_pkg::OP_XWR_R0)
                      || (opcode_reg == cycle_timing_pkg::OP_XWR_R1);
  assign is_movx_rd = (opcode_reg == cycle_timing_pkg::OP_XRD_DPTR)
                      || (opcode_reg == cycle_timing_pkg::OP_XRD_R0)
                      || (opcode_reg == cycle_timing_pkg::OP_XRD_R1);
  assign is_movc    = (opcode_reg == cycle_timing_pkg::OP_MOVC_PC)
                      || (opcode_reg == cycle_timing_pkg::OP_MOVC_DPTR);

  // no off-chip strobes exist; data moves land on on-chip ram or flash
  assign xram_rd_stb  = last_cycle && is_movx_rd; // RQ19
  assign xram_wr_stb  = last_cycle && is_movx_wr && !store_we_reg; // RQ19
  assign flash_wr_stb = last_cycle && is_movx_wr && store_we_reg; // RQ18
  assign code_rd_stb  = last_cycle && is_movc;

  assign busy        = (state_reg == cycle_timing_pkg::ST_EXEC);
  assign inst_done   = last_cycle;
  assign inst_len    = len_reg;
  assign inst_cycles = cyc_reg;
  assign inst_cond   = cond_reg;
  assign cur_opcode  = opcode_reg;

  chk_clock_step: assert property ( // RQ1
    @(posedge clock) disable iff (rst)
    busy && !last_cycle |=> count == $past(count) - CW'(1))
    else $error("execution count did not step by one clock");

  chk_taken_length: assert property ( // RQ2
    @(posedge clock) disable iff (rst)
    last_cycle && !skip_cycle |-> elapsed_reg == cyc_reg)
    else $error("instruction ended off its cycle count");

  chk_untaken_early: assert property ( // RQ3
    @(posedge clock) disable iff (rst)
    last_cycle && skip_cycle |-> elapsed_reg == cyc_reg - CW'(1))
    else $error("untaken branch did not end one clock early");

  chk_reg_source: assert property ( // RQ4
    @(posedge clock) disable iff (rst)
    accept && op_byte[3] && (op_byte[7:4] inside {4'h0, 4'h1, 4'h2,
      4'h3, 4'h4, 4'h5, 4'h6, 4'h9})
    |=> inst_len == 2'h1 && inst_cycles == 4'h1 && last_cycle)
    else $error("register-source op not one byte one clock");

  chk_direct_src: assert property ( // RQ5
    @(posedge clock) disable iff (rst)
    accept && op_byte[3:0] == 4'h5 && (op_byte[7:4] inside {4'h0,
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9})
    |=> inst_len == 2'h2 ##1 last_cycle)
    else $error("direct-operand op not two bytes two clocks");

  chk_indirect_src: assert property ( // RQ6
    @(posedge clock) disable iff (rst)
    accept && op_byte[3:1] == 3'h3 && (op_byte[7:4] inside {4'h0,
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9})
    |=> inst_len == 2'h1 && !last_cycle ##1 last_cycle)
    else $error("indirect op not one byte two clocks");

  chk_logic_imm: assert property ( // RQ8
    @(posedge clock) disable iff (rst)
    accept && op_byte[3:0] == 4'h3 && (op_byte[7:4] inside {4'h4,
      4'h5, 4'h6})
    |=> inst_len == 2'h3 && !last_cycle ##1 !last_cycle ##1 last_cycle)
    else $error("logic immediate to direct not three clocks");

  chk_code_read: assert property ( // RQ16
    @(posedge clock) disable iff (rst)
    accept && (op_byte == cycle_timing_pkg::OP_MOVC_PC
      || op_byte == cycle_timing_pkg::OP_MOVC_DPTR)
    |=> inst_len == 2'h1 ##2 code_rd_stb)
    else $error("code read not one byte three clocks");

  chk_xdata_three: assert property ( // RQ17
    @(posedge clock) disable iff (rst)
    accept && op_byte[7:5] == 3'h7 && (op_byte[3:0] inside {4'h0,
      4'h2, 4'h3})
    |=> inst_len == 2'h1 && !last_cycle [*2] ##1 last_cycle)
    else $error("external-data move not one byte three clocks");

  chk_flash_path: assert property ( // RQ18
    @(posedge clock) disable iff (rst)
    last_cycle && is_movx_wr |-> flash_wr_stb == store_we_reg)
    else $error("data write did not steer to flash as enabled");

  chk_no_dual_write: assert property ( // RQ19
    @(posedge clock) disable iff (rst)
    !(xram_wr_stb && flash_wr_stb))
    else $error("write reached ram and flash together");

  chk_cycle_ceiling: assert property ( // RQ22
    @(posedge clock) disable iff (rst)
    busy |-> count <= cycle_timing_pkg::MAX_CYCLES
      && elapsed_reg <= cycle_timing_pkg::MAX_CYCLES)
    else $error("instruction ran past eight clocks");

  chk_spare_nop: assert property ( // RQ23
    @(posedge clock) disable iff (rst)
    accept && op_byte == cycle_timing_pkg::OP_SPARE
    |=> inst_len == 2'h1 && !inst_cond && last_cycle)
    else $error("spare opcode not timed as no-operation");

  chk_multiply: assert property ( // RQ24
    @(posedge clock) disable iff (rst)
    accept && op_byte == cycle_timing_pkg::OP_MUL
    |=> !last_cycle [*3] ##1 last_cycle)
    else $error("multiply not four clocks");

  chk_divide: assert property ( // RQ24
    @(posedge clock) disable iff (rst)
    accept && op_byte == cycle_timing_pkg::OP_DIV
    |=> inst_len == 2'h1 && inst_cycles == 4'h8 ##7 last_cycle)
    else $error("divide not eight clocks");

endmodule : cpu_instruction_cycle_timing

//--- cycle_timing_pkg.sv
// constants for the instruction length and cycle-count decoder
// assumes one system clock; every count is in single clock cycles
package cycle_timing_pkg;

  localparam int LEN_W = 2;
  localparam int CYC_W = 4;

  // longest instruction, in clocks
  localparam logic [CYC_W-1:0] MAX_CYCLES = 4'h8;

  // decode entry layout: {cond, len[1:0], cycles[3:0]}
  localparam int ENT_W        = 7;
  localparam int ENT_COND_BIT = 6;
  localparam int ENT_LEN_LSB  = 4;
  localparam int ENT_CYC_LSB  = 0;

  // entry classes, Eab = a bytes b clocks, Cab = conditional (b if taken)
  localparam logic [ENT_W-1:0] E11 = 7'h11;
  localparam logic [ENT_W-1:0] E12 = 7'h12;
  localparam logic [ENT_W-1:0] E13 = 7'h13;
  localparam logic [ENT_W-1:0] E14 = 7'h14;
  localparam logic [ENT_W-1:0] E15 = 7'h15;
  localparam logic [ENT_W-1:0] E18 = 7'h18;
  localparam logic [ENT_W-1:0] E22 = 7'h22;
  localparam logic [ENT_W-1:0] E23 = 7'h23;
  localparam logic [ENT_W-1:0] E33 = 7'h33;
  localparam logic [ENT_W-1:0] E34 = 7'h34;
  localparam logic [ENT_W-1:0] C23 = 7'h63;
  localparam logic [ENT_W-1:0] C34 = 7'h74;
  localparam logic [ENT_W-1:0] C35 = 7'h75;

  // opcodes with side effects or special checks
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_SPARE     = 8'ha5;
  localparam logic [7:0] OP_MUL       = 8'ha4;
  localparam logic [7:0] OP_DIV       = 8'h84;
  localparam logic [7:0] OP_MOVC_PC   = 8'h83;
  localparam logic [7:0] OP_MOVC_DPTR = 8'h93;
  localparam logic [7:0] OP_XRD_DPTR  = 8'he0;
  localparam logic [7:0] OP_XRD_R0    = 8'he2;
  localparam logic [7:0] OP_XRD_R1    = 8'he3;
  localparam logic [7:0] OP_XWR_DPTR  = 8'hf0;
  localparam logic [7:0] OP_XWR_R0    = 8'hf2;
  localparam logic [7:0] OP_XWR_R1    = 8'hf3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } seq_state_type;

endpackage : cycle_timing_pkg

//--- exec_cycle_counter.sv
// down counter of remaining execution clocks
// assumes load comes from logic on the same clock
module exec_cycle_counter #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic      [W-1:0] count
);

  logic [W-1:0] count_reg;

  // one step per clock, no machine-cycle prescaler
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - W'(1); // RQ1
    end
  end

  assign count = count_reg;

endmodule : exec_cycle_counter

//--- mem_side_model.sv
// memory-side partner: counts the access strobes reaching on-chip storage
// assumes strobes are one-clock pulses on the system clock
module mem_side_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        code_rd_stb,
  input  wire logic        xram_rd_stb,
  input  wire logic        xram_wr_stb,
  input  wire logic        flash_wr_stb,
  output logic      [15:0] code_reads,
  output logic      [15:0] xram_reads,
  output logic      [15:0] xram_writes,
  output logic      [15:0] flash_writes
);
  timeunit 1ns;
  timeprecision 100ps;

  // no external bus exists, so every data access lands here
  always_ff @(posedge clock) begin
    if (rst) begin
      code_reads   <= 16'h0000;
      xram_reads   <= 16'h0000;
      xram_writes  <= 16'h0000;
      flash_writes <= 16'h0000;
    end else begin
      code_reads   <= code_reads + 16'(code_rd_stb);
      xram_reads   <= xram_reads + 16'(xram_rd_stb);
      xram_writes  <= xram_writes + 16'(xram_wr_stb);
      flash_writes <= flash_writes + 16'(flash_wr_stb);
    end
  end
endmodule : mem_side_model

//--- tb_cpu_instruction_cycle_timing.sv
// self-checking bench for the instruction length and cycle decoder
// assumes one 20 MHz clock and the memory-side model beside the design
module tb_cpu_instruction_cycle_timing;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [7:0] op;
    logic [1:0] len;
    logic [3:0] cyc;
    logic       cond;
    logic [3:0] stb;
    int         dur;
    int         at;
  } exp_type;

  localparam int NUM = 61;
  // entry {opcode, cond, len, clocks}; conditional clocks are the taken count
  localparam logic [15:0] TBL [NUM] = '{
    16'h2811, 16'h3811, 16'h9811, 16'h5811, 16'h4811, 16'h6811,
    16'h0411, 16'h1411, 16'h0811, 16'h1811, 16'hc811,
    16'h2522, 16'h0522, 16'h1522, 16'h2422, 16'h5422,
    16'h5222, 16'h4222, 16'h6222, 16'hc522,
    16'h2612, 16'h0612, 16'h1612, 16'h5712, 16'hf612,
    16'h5333, 16'h4333, 16'h6333, 16'h8533, 16'h7533, 16'h9033,
    16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
    16'hc411, 16'hd411,
    16'h7622, 16'ha622, 16'h8622, 16'ha822, 16'h7822,
    16'hc022, 16'hd022,
    16'h8313, 16'h9313, 16'he013, 16'he213, 16'he313,
    16'hf013, 16'hf213, 16'hf313,
    16'ha414, 16'h8418, 16'ha511, 16'h0011,
    16'h4063, 16'h2074, 16'hb675
  };

  logic        clock;
  logic        rst;
  logic        op_valid;
  logic [7:0]  op_byte;
  logic        op_ready;
  logic        branch_taken;
  logic        store_write_en;
  logic        busy;
  logic        inst_done;
  logic [1:0]  inst_len;
  logic [3:0]  inst_cycles;
  logic        inst_cond;
  logic [7:0]  cur_opcode;
  logic        code_rd_stb;
  logic        xram_rd_stb;
  logic        xram_wr_stb;
  logic        flash_wr_stb;
  logic [15:0] code_reads;
  logic [15:0] xram_reads;
  logic [15:0] xram_writes;
  logic [15:0] flash_writes;
  exp_type     exq [$];
  int          mismatches;
  int          cmp_count;
  int          cyc;
  int          seed;
  int          cnt [4];

  cpu_instruction_cycle_timing cpu_instruction_cycle_timing_i (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_byte(op_byte),
    .op_ready(op_ready), .branch_taken(branch_taken),
    .store_write_en(store_write_en), .busy(busy), .inst_done(inst_done),
    .inst_len(inst_len), .inst_cycles(inst_cycles), .inst_cond(inst_cond),
    .cur_opcode(cur_opcode), .code_rd_stb(code_rd_stb),
    .xram_rd_stb(xram_rd_stb), .xram_wr_stb(xram_wr_stb),
    .flash_wr_stb(flash_wr_stb)
  );

  mem_side_model mem_side_model_i (
    .clock(clock), .rst(rst), .code_rd_stb(code_rd_stb),
    .xram_rd_stb(xram_rd_stb), .xram_wr_stb(xram_wr_stb),
    .flash_wr_stb(flash_wr_stb), .code_reads(code_reads),
    .xram_reads(xram_reads), .xram_writes(xram_writes),
    .flash_writes(flash_writes)
  );

  always #25 clock = ~clock;

  always @(posedge clock) cyc <= cyc + 1;

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // offer held until taken; caller lowers op_valid via idle
  task automatic issue(input int idx, input logic tk, input logic se);
    exp_type    x;
    logic [7:0] o;
    logic       wr;
    int         n;
    o = TBL[idx][15:8];
    wr = (o == 8'hf0 || o == 8'hf2 || o == 8'hf3);
    op_valid = 1'b1;
    op_byte = o;
    store_write_en = se;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (op_ready !== 1'b1 && n < 20);
    x.op = o;
    x.cond = TBL[idx][6];
    x.len = TBL[idx][5:4];
    x.cyc = TBL[idx][3:0];
    x.dur = (x.cond && !tk) ? int'(x.cyc) - 1 : int'(x.cyc);
    x.stb[3] = (o == 8'h83 || o == 8'h93);
    x.stb[2] = (o == 8'he0 || o == 8'he2 || o == 8'he3);
    x.stb[1] = wr && !se;
    x.stb[0] = wr && se;
    x.at = cyc;
    exq.push_back(x);
    for (int k = 0; k < 4; k++) cnt[k] += int'(x.stb[3-k]);
    check("accept wait", 16'(n >= 20), 16'h0000);
    #2;
    // taken result changes only after the previous one was consumed
    branch_taken = tk;
    check("fetch length", 16'(inst_len), 16'(x.len));
  endtask : issue

  task automatic idle(input int n);
    op_valid = 1'b0;
    op_byte = ~op_byte;
    repeat (n) @(posedge clock);
    #2;
  endtask : idle

  always @(posedge clock) begin : monitor
    exp_type x;
    if (rst) begin
      exq.delete();
    end else begin
      check("strobe off end", 16'({code_rd_stb, xram_rd_stb, xram_wr_stb,
            flash_wr_stb} & {4{~inst_done}}), 16'h0000);
      if (exq.size() == 0 && inst_done !== 1'b1) begin
        check("busy idle", 16'(busy), 16'h0000);
      end
      if (inst_done === 1'b1) begin
        check("busy at end", 16'(busy), 16'h0001);
        if (exq.size() == 0) begin
          check("end unasked", 16'h0001, 16'h0000);
        end else begin
          x = exq.pop_front();
          check("opcode", 16'(cur_opcode), 16'(x.op));
          check("length", 16'(inst_len), 16'(x.len));
          check("cycles", 16'(inst_cycles), 16'(x.cyc));
          check("cond", 16'(inst_cond), 16'(x.cond));
          check("clocks", 16'(cyc - x.at), 16'(x.dur));
          check("max clocks", 16'(cyc - x.at > 8), 16'h0000);
          check("strobes", 16'({code_rd_stb, xram_rd_stb, xram_wr_stb,
                flash_wr_stb}), 16'(x.stb));
        end
      end
    end
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    op_valid = 1'b0;
    op_byte = 8'h00;
    branch_taken = 1'b0;
    store_write_en = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    seed = 24807;
    cnt = '{default: 0};
    repeat (16) @(posedge clock);
    #2;
    rst = 1'b0;
    check("reset state", 16'({busy, op_ready, inst_done, inst_len,
          inst_cycles}), 16'h0080);
    check("reset opcode", 16'(cur_opcode), 16'h0000);
    // whole table back to back: taken and plain writes, then the reverse
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < NUM; i++) begin
        issue(i, p == 0, p == 1);
      end
      idle(3);
    end
    for (int k = 0; k < 300; k++) begin
      issue(($random(seed) & 32'h7fff) % NUM, 1'($random(seed)),
            1'($random(seed)));
      if (($random(seed) & 3) == 0) begin
        idle(1 + ($random(seed) & 3));
      end
    end
    idle(12);
    check("code reads", code_reads, 16'(cnt[0]));
    check("xram reads", xram_reads, 16'(cnt[1]));
    check("xram writes", xram_writes, 16'(cnt[2]));
    check("flash writes", flash_writes, 16'(cnt[3]));
    // divide cut short by reset must never report an end
    issue(NUM - 6, 1'b1, 1'b0);
    idle(3);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    check("abort state", 16'({busy, op_ready, inst_done}), 16'h0002);
    idle(10);
    check("pending", 16'(exq.size()), 16'h0000);
    results();
  end

  // far beyond the roughly one thousand clocks the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("BAD watchdog expected end seen hang");
    results();
  end
endmodule : tb_cpu_instruction_cycle_timing
